// ---- can_rx_cfg.sv ----
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
module can_rx_cfg #(
    parameter int DEBUG_ELEM_WORDS = 4
) (
    input wire logic REF_CLK,
    input wire logic RESETN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic PROTECT_WRITE_OK,
    input wire logic [6:0] FIFO0_SIZE,
    input wire logic [5:0] FIFO0_PUT_INDEX,
    input wire logic FIFO0_FULL,
    output logic [5:0] FIFO0_GET_INDEX,
    output logic [6:0] FIFO0_FILL_LEVEL,
    output logic [13:0] RX_BUFFER_START_ADDR,
    output logic [13:0] DEBUG_MSG_A_ADDR,
    output logic [13:0] DEBUG_MSG_B_ADDR,
    output logic [13:0] DEBUG_MSG_C_ADDR,
    output logic FIFO1_OPERATING_MODE,
    output logic FIFO1_OVERWRITE,
    output logic FIFO1_BLOCKING,
    output logic [6:0] FIFO1_WATERMARK,
    output logic [6:0] FIFO1_SIZE,
    output logic [5:0] FIFO1_LAST_INDEX,
    output logic [13:0] FIFO1_START_ADDR,
    input wire logic [6:0] FIFO1_FILL_LEVEL,
    output logic FIFO1_WATERMARK_FLAG
);
    // ****************************************
    // bus decode
    // ****************************************
    logic [31:0] rx_fifo0_acknowledge;
    logic [31:0] rx_buffer_config;
    logic [31:0] rx_fifo1_config;
    logic [5:0] fifo0_get_index;
    logic [6:0] fifo0_fill_level;
    logic wm_hit_d;

    wire access = PSEL && PENABLE;
    wire wr = access && PWRITE;
    wire hit_ack = PADDR == can_rx_cfg_pkg::RX_FIFO0_ACKNOWLEDGE_OFS;
    wire hit_rxbc = PADDR == can_rx_cfg_pkg::RX_BUFFER_CONFIG_OFS;
    wire hit_f1c = PADDR == can_rx_cfg_pkg::RX_FIFO1_CONFIG_OFS;
    wire hit_state = PADDR == can_rx_cfg_pkg::RX_FIFO0_STATE_OFS;
    wire mapped = hit_ack || hit_rxbc || hit_f1c || hit_state;
    wire wr_ack = wr && hit_ack;
    // protected fields take a write only while allowed
    wire wr_rxbc = wr && hit_rxbc && PROTECT_WRITE_OK; // [R11]
    wire wr_f1c = wr && hit_f1c && PROTECT_WRITE_OK; // [R11]

    assign PREADY = 1'b1;
    assign PSLVERR = access && !mapped;

    // ****************************************
    // fifo 0 acknowledge and pointers
    // ****************************************
    wire [5:0] ack_value = PWDATA[can_rx_cfg_pkg::ACK_INDEX_LSB +:
        can_rx_cfg_pkg::ACK_INDEX_W]; // [R1]
    wire [6:0] f0_size = (FIFO0_SIZE > can_rx_cfg_pkg::FIFO_MAX_ELEMS) ?
        can_rx_cfg_pkg::FIFO_MAX_ELEMS : FIFO0_SIZE;
    wire [6:0] ack_plus = {1'b0, ack_value} + 7'h01; // [R2]
    // wrap at the configured size
    wire [5:0] next_get_wrapped = (ack_plus >= f0_size) ? 6'h00 :
        ack_plus[5:0]; // [R15]
    wire [5:0] next_fifo0_get_index = wr_ack ? next_get_wrapped :
        fifo0_get_index; // [R2] [R13]
    wire [6:0] put_ext = {1'b0, FIFO0_PUT_INDEX};
    wire [6:0] get_ext = {1'b0, next_fifo0_get_index};
    wire [6:0] span = (put_ext >= get_ext) ? (put_ext - get_ext) :
        7'((put_ext + f0_size) - get_ext); // [R15]
    // full reads as size, empty size reads as zero
    wire [6:0] next_fifo0_fill_level = (f0_size == 7'h00) ? 7'h00 :
        FIFO0_FULL ? f0_size : span; // [R14]

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rx_fifo0_acknowledge <= can_rx_cfg_pkg::RX_FIFO0_ACKNOWLEDGE_RST; // [R12]
            fifo0_get_index <= 6'h00;
            fifo0_fill_level <= 7'h00;
        end else begin
            if (wr_ack) begin
                rx_fifo0_acknowledge <= PWDATA & can_rx_cfg_pkg::ACK_MASK; // [R3]
            end
            fifo0_get_index <= next_fifo0_get_index; // [R2]
            fifo0_fill_level <= next_fifo0_fill_level; // [R2]
        end
    end

    assign FIFO0_GET_INDEX = fifo0_get_index;
    assign FIFO0_FILL_LEVEL = fifo0_fill_level;

    // ****************************************
    // protected configuration registers
    // ****************************************
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rx_buffer_config <= can_rx_cfg_pkg::RX_BUFFER_CONFIG_RST;
            rx_fifo1_config <= can_rx_cfg_pkg::RX_FIFO1_CONFIG_RST;
        end else begin
            if (wr_rxbc) begin
                rx_buffer_config <= PWDATA & can_rx_cfg_pkg::RXBC_MASK; // [R3] [R4]
            end
            if (wr_f1c) begin
                rx_fifo1_config <= PWDATA & can_rx_cfg_pkg::RXF1C_MASK; // [R3]
            end
        end
    end

    // ****************************************
    // rx buffer section and debug messages
    // ****************************************
    wire [13:0] rx_buffer_start_addr = rx_buffer_config[
        can_rx_cfg_pkg::START_ADDR_LSB +: can_rx_cfg_pkg::START_ADDR_W]; // [R4]
    wire [13:0] dbg_step = 14'(DEBUG_ELEM_WORDS);
    assign RX_BUFFER_START_ADDR = rx_buffer_start_addr;
    assign DEBUG_MSG_A_ADDR = rx_buffer_start_addr; // [R5]
    assign DEBUG_MSG_B_ADDR = 14'(rx_buffer_start_addr + dbg_step); // [R5]
    assign DEBUG_MSG_C_ADDR = 14'(rx_buffer_start_addr + {dbg_step[12:0],
        1'b0}); // [R5]

    // ****************************************
    // fifo 1 fields
    // ****************************************
    wire fifo1_operating_mode = rx_fifo1_config[can_rx_cfg_pkg::F1_MODE_BIT];
    wire [6:0] fifo1_watermark = rx_fifo1_config[can_rx_cfg_pkg::F1_WM_LSB +:
        can_rx_cfg_pkg::FIELD7_W];
    wire [6:0] fifo1_size_raw = rx_fifo1_config[can_rx_cfg_pkg::F1_SIZE_LSB +:
        can_rx_cfg_pkg::FIELD7_W];
    wire [6:0] fifo1_size = (fifo1_size_raw > can_rx_cfg_pkg::FIFO_MAX_ELEMS) ?
        can_rx_cfg_pkg::FIFO_MAX_ELEMS : fifo1_size_raw; // [R8]
    wire [6:0] f1_last = fifo1_size - 7'h01;
    wire wm_enabled = (fifo1_watermark != 7'h00) &&
        (fifo1_watermark <= can_rx_cfg_pkg::FIFO_MAX_ELEMS); // [R7]
    wire wm_hit = wm_enabled && (FIFO1_FILL_LEVEL >= fifo1_watermark); // [R7]

    assign FIFO1_OPERATING_MODE = fifo1_operating_mode;
    assign FIFO1_OVERWRITE = fifo1_operating_mode; // [R6]
    assign FIFO1_BLOCKING = !fifo1_operating_mode; // [R6]
    assign FIFO1_WATERMARK = fifo1_watermark;
    assign FIFO1_SIZE = fifo1_size;
    // highest element index, zero when no fifo 1
    assign FIFO1_LAST_INDEX = (fifo1_size == 7'h00) ? 6'h00 :
        f1_last[5:0]; // [R9]
    assign FIFO1_START_ADDR = rx_fifo1_config[can_rx_cfg_pkg::START_ADDR_LSB +:
        can_rx_cfg_pkg::START_ADDR_W]; // [R10]

    // one pulse when the level first reaches the watermark
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            wm_hit_d <= 1'b0;
        end else begin
            wm_hit_d <= wm_hit;
        end
    end
    assign FIFO1_WATERMARK_FLAG = wm_hit && !wm_hit_d; // [R7]

    // ****************************************
    // read data
    // ****************************************
    wire [31:0] state_word = ({24'h000000, 2'b00, fifo0_get_index}
        << can_rx_cfg_pkg::STATE_GET_LSB) | ({25'h0, fifo0_fill_level}
        << can_rx_cfg_pkg::STATE_FILL_LSB);
    wire [31:0] next_prdata = !mapped ? 32'h0000_0000 :
        hit_ack ? rx_fifo0_acknowledge :
        hit_rxbc ? rx_buffer_config :
        hit_f1c ? rx_fifo1_config : state_word; // [R3]

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            PRDATA <= 32'h0000_0000;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            PRDATA <= next_prdata;
        end
    end
endmodule : can_rx_cfg

// ---- can_rx_cfg_pkg.sv ----
// How it works
// [R1] software writes the index of the last fifo 0 element read to ack.
// [R2] an ack write sets get index to ack plus one and recomputes fill.
// [R3] reserved bits of the three registers read zero, writes ignored.
// [R4] rx buffer config holds the buffer section word address.
// [R5] debug messages a, b, c are located from the rx buffer start.
// [R6] fifo 1 mode 0 is blocking, 1 is overwrite.
// [R7] fifo 1 watermark 0 or above 64 disables, 1..64 sets the level.
// [R8] fifo 1 size 0 means none, 1..64 elements, above 64 acts as 64.
// [R9] fifo 1 elements run from index 0 to size minus one.
// [R10] fifo 1 start field holds the fifo 1 word address.
// [R11] buffer start and fifo 1 fields change only when protected ok.
// [R12] the fifo 0 ack register resets to zero.
// [R13] fifo 0 get index is a read pointer from 0 to 63.
// [R14] fifo 0 fill level counts stored elements from 0 to 64.
// [R15] get index wraps to zero at size; fill is put minus get mod size.
package can_rx_cfg_pkg;
    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] RX_FIFO0_ACKNOWLEDGE_OFS = 8'ha8;
    localparam logic [7:0] RX_BUFFER_CONFIG_OFS = 8'hac;
    localparam logic [7:0] RX_FIFO1_CONFIG_OFS = 8'hb0;
    localparam logic [7:0] RX_FIFO0_STATE_OFS = 8'hc0;
    // ****************************************
    // field positions
    // ****************************************
    localparam int ACK_INDEX_LSB = 0;
    localparam int ACK_INDEX_W = 6;
    localparam int START_ADDR_LSB = 2;
    localparam int START_ADDR_W = 14;
    localparam int F1_SIZE_LSB = 16;
    localparam int F1_WM_LSB = 24;
    localparam int FIELD7_W = 7;
    localparam int F1_MODE_BIT = 31;
    localparam int STATE_GET_LSB = 8;
    localparam int STATE_FILL_LSB = 16;
    // ****************************************
    // reset values and limits
    // ****************************************
    localparam logic [31:0] RX_FIFO0_ACKNOWLEDGE_RST = 32'h0000_0000;
    localparam logic [31:0] RX_BUFFER_CONFIG_RST = 32'h0000_0000;
    localparam logic [31:0] RX_FIFO1_CONFIG_RST = 32'h0000_0000;
    localparam logic [6:0] FIFO_MAX_ELEMS = 7'h40;
    localparam logic [31:0] ACK_MASK = 32'h0000_003f;
    localparam logic [31:0] RXBC_MASK = 32'h0000_fffc;
    localparam logic [31:0] RXF1C_MASK = 32'hff7f_fffc;
endpackage : can_rx_cfg_pkg

// ---- can_rx_cfg_props.sv ----
`timescale 1ns/10ps
// ****
// checker
// ****
module can_rx_cfg_props (
    input logic REF_CLK,
    input logic RESETN,
    input logic PSEL,
    input logic PENABLE,
    input logic PWRITE,
    input logic [7:0] PADDR,
    input logic [31:0] PWDATA,
    input logic [31:0] PRDATA,
    input logic PROTECT_WRITE_OK,
    input logic [13:0] RX_BUFFER_START_ADDR,
    input logic [13:0] DEBUG_MSG_A_ADDR,
    input logic FIFO1_OPERATING_MODE,
    input logic FIFO1_BLOCKING,
    input logic [6:0] FIFO1_SIZE,
    input logic [5:0] FIFO1_LAST_INDEX,
    input logic [13:0] FIFO1_START_ADDR
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);
    wire acc = PSEL && PENABLE;
    wire wr = acc && PWRITE && PROTECT_WRITE_OK;
    mode_split_a: assert property (
        FIFO1_BLOCKING != FIFO1_OPERATING_MODE) else $error("mode split");
    size_clamp_a: assert property (
        FIFO1_SIZE <= 7'h40) else $error("size above 64");
    last_index_a: assert property (
        FIFO1_SIZE != 7'h00 |-> FIFO1_LAST_INDEX == 6'(FIFO1_SIZE - 7'h01))
        else $error("last index");
    debug_base_a: assert property (
        DEBUG_MSG_A_ADDR == RX_BUFFER_START_ADDR) else $error("debug base");
    buf_write_a: assert property (
        wr && PADDR == can_rx_cfg_pkg::RX_BUFFER_CONFIG_OFS |=>
        RX_BUFFER_START_ADDR == $past(PWDATA[15:2]))
        else $error("buffer start");
    f1_start_a: assert property (
        wr && PADDR == can_rx_cfg_pkg::RX_FIFO1_CONFIG_OFS |=>
        FIFO1_START_ADDR == $past(PWDATA[15:2]))
        else $error("fifo1 start");
    prot_hold_a: assert property (
        acc && PWRITE && !PROTECT_WRITE_OK |=>
        $stable(RX_BUFFER_START_ADDR) && $stable(FIFO1_START_ADDR))
        else $error("protected write");
    ack_zero_a: assert property (
        acc && !PWRITE && PADDR == can_rx_cfg_pkg::RX_FIFO0_ACKNOWLEDGE_OFS
        |-> PRDATA[31:6] == 26'h0)
        else $error("reserved bits");
endmodule : can_rx_cfg_props
bind can_rx_cfg can_rx_cfg_props props_i (
    .REF_CLK(REF_CLK),
    .RESETN(RESETN),
    .PSEL(PSEL),
    .PENABLE(PENABLE),
    .PWRITE(PWRITE),
    .PADDR(PADDR),
    .PWDATA(PWDATA),
    .PRDATA(PRDATA),
    .PROTECT_WRITE_OK(PROTECT_WRITE_OK),
    .RX_BUFFER_START_ADDR(RX_BUFFER_START_ADDR),
    .DEBUG_MSG_A_ADDR(DEBUG_MSG_A_ADDR),
    .FIFO1_OPERATING_MODE(FIFO1_OPERATING_MODE),
    .FIFO1_BLOCKING(FIFO1_BLOCKING),
    .FIFO1_SIZE(FIFO1_SIZE),
    .FIFO1_LAST_INDEX(FIFO1_LAST_INDEX),
    .FIFO1_START_ADDR(FIFO1_START_ADDR)
);

// ---- testbench.sv ----
`timescale 1ns/10ps
// ****
// bench
// ****
module testbench;
    localparam int DW = 4;
    logic REF_CLK = '0, RESETN = '0, PSEL = '0, PENABLE = '0, PWRITE = '0;
    logic PROTECT_WRITE_OK = 1'b1, FIFO0_FULL = '0, PREADY, PSLVERR, err;
    logic [7:0] PADDR = '0;
    logic [31:0] PWDATA = '0, PRDATA, rd;
    logic [6:0] FIFO0_SIZE = 7'h08, FIFO1_FILL_LEVEL = '0, FIFO0_FILL_LEVEL;
    logic [6:0] FIFO1_WATERMARK, FIFO1_SIZE;
    logic [5:0] FIFO0_PUT_INDEX = 6'h05, FIFO0_GET_INDEX, FIFO1_LAST_INDEX;
    logic [13:0] RX_BUFFER_START_ADDR, DEBUG_MSG_A_ADDR, DEBUG_MSG_B_ADDR;
    logic [13:0] DEBUG_MSG_C_ADDR, FIFO1_START_ADDR;
    logic FIFO1_OPERATING_MODE, FIFO1_OVERWRITE, FIFO1_BLOCKING;
    logic FIFO1_WATERMARK_FLAG;
    int failures = 0, n_compared = 0;
    can_rx_cfg #(.DEBUG_ELEM_WORDS(DW)) DUT (
        .REF_CLK(REF_CLK), .RESETN(RESETN), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .PROTECT_WRITE_OK(PROTECT_WRITE_OK),
        .FIFO0_SIZE(FIFO0_SIZE), .FIFO0_PUT_INDEX(FIFO0_PUT_INDEX),
        .FIFO0_FULL(FIFO0_FULL), .FIFO0_GET_INDEX(FIFO0_GET_INDEX),
        .FIFO0_FILL_LEVEL(FIFO0_FILL_LEVEL),
        .RX_BUFFER_START_ADDR(RX_BUFFER_START_ADDR),
        .DEBUG_MSG_A_ADDR(DEBUG_MSG_A_ADDR),
        .DEBUG_MSG_B_ADDR(DEBUG_MSG_B_ADDR),
        .DEBUG_MSG_C_ADDR(DEBUG_MSG_C_ADDR),
        .FIFO1_OPERATING_MODE(FIFO1_OPERATING_MODE),
        .FIFO1_OVERWRITE(FIFO1_OVERWRITE),
        .FIFO1_BLOCKING(FIFO1_BLOCKING),
        .FIFO1_WATERMARK(FIFO1_WATERMARK), .FIFO1_SIZE(FIFO1_SIZE),
        .FIFO1_LAST_INDEX(FIFO1_LAST_INDEX),
        .FIFO1_START_ADDR(FIFO1_START_ADDR),
        .FIFO1_FILL_LEVEL(FIFO1_FILL_LEVEL),
        .FIFO1_WATERMARK_FLAG(FIFO1_WATERMARK_FLAG)
    );
    always #5 REF_CLK = ~REF_CLK;
    task report_and_stop;
        if (failures == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge REF_CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge REF_CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        if (n >= 20) begin
            failures++;
            report_and_stop;
        end
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        #1;
    endtask : apb
    task rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdchk
    task fill1(input logic [6:0] f, input logic exp);
        @(posedge REF_CLK);
        FIFO1_FILL_LEVEL <= f;
        #1;
        chk(FIFO1_WATERMARK_FLAG, exp);
    endtask : fill1
    initial begin
        repeat (12) @(posedge REF_CLK);
        RESETN <= 1'b1;
        rdchk(8'ha8, 32'h0);
        apb(1'b1, 8'hac, 32'hffff_ffff);
        rdchk(8'hac, 32'h0000_fffc);
        chk(RX_BUFFER_START_ADDR, 32'h3fff);
        chk(DEBUG_MSG_A_ADDR, 32'h3fff);
        chk(DEBUG_MSG_B_ADDR, 14'(14'h3fff + DW));
        chk(DEBUG_MSG_C_ADDR, 14'(14'h3fff + 2 * DW));
        apb(1'b1, 8'hb0, 32'hffff_ffff);
        rdchk(8'hb0, 32'hff7f_fffc);
        chk(FIFO1_SIZE, 32'h40);
        chk(FIFO1_LAST_INDEX, 32'h3f);
        chk(FIFO1_OVERWRITE, 32'h1);
        chk(FIFO1_OPERATING_MODE, 32'h1);
        chk(FIFO1_WATERMARK, 32'h7f);
        @(posedge REF_CLK);
        PROTECT_WRITE_OK <= 1'b0;
        apb(1'b1, 8'hac, 32'h0);
        apb(1'b1, 8'hb0, 32'h0);
        rdchk(8'hac, 32'h0000_fffc);
        chk(FIFO1_START_ADDR, 32'h3fff);
        @(posedge REF_CLK);
        PROTECT_WRITE_OK <= 1'b1;
        apb(1'b1, 8'hb0, 32'h0305_1234);
        chk(FIFO1_BLOCKING, 32'h1);
        chk(FIFO1_OPERATING_MODE, 32'h0);
        chk(FIFO1_WATERMARK, 32'h03);
        chk(FIFO1_LAST_INDEX, 32'h4);
        chk(FIFO1_START_ADDR, 32'h048d);
        fill1(7'h02, 1'b0);
        fill1(7'h03, 1'b1);
        fill1(7'h03, 1'b0);
        fill1(7'h00, 1'b0);
        apb(1'b1, 8'hb0, 32'h0005_0000);
        chk(FIFO1_WATERMARK_FLAG, 32'h0);
        fill1(7'h01, 1'b0);
        apb(1'b1, 8'hb0, 32'h4105_0000);
        fill1(7'h41, 1'b0);
        apb(1'b1, 8'ha8, 32'h2);
        chk(FIFO0_GET_INDEX, 32'h3);
        chk(FIFO0_FILL_LEVEL, 32'h2);
        apb(1'b1, 8'ha8, 32'hffff_ffc7);
        chk(FIFO0_GET_INDEX, 32'h0);
        rdchk(8'ha8, 32'h0000_0007);
        rdchk(8'hc0, 32'h0005_0000);
        @(posedge REF_CLK);
        FIFO0_FULL <= 1'b1;
        fill1(7'h00, 1'b0);
        chk(FIFO0_FILL_LEVEL, 32'h8);
        rdchk(8'h10, 32'h0);
        chk(err, 32'h1);
        report_and_stop;
    end
    initial begin
        #20000;
        failures++;
        report_and_stop;
    end
endmodule : testbench
